// ---- crc_pkg.sv ----
package crc_pkg;

    // ****************************************
    // register map (byte offsets)
    // ****************************************
    localparam logic [7:0] CRC_OFS_EVENTS = 8'h08;
    localparam logic [7:0] CRC_OFS_FAST_RST = 8'h0c;
    localparam logic [7:0] CRC_OFS_SLOW_RST = 8'h10;
    localparam logic [7:0] CRC_OFS_SUPV_CTRL = 8'h20;

    // ****************************************
    // event register fields
    // ****************************************
    localparam int CRC_NUM_READY = 5;
    localparam int CRC_BIT_READY_FLAG = 0;
    localparam int CRC_BIT_FAIL_FLAG = 7;
    localparam int CRC_BIT_READY_IE = 8;
    localparam int CRC_BIT_READY_CLR = 16;
    localparam int CRC_BIT_FAIL_CLR = 23;

    // ****************************************
    // writable masks of the module reset registers
    // ****************************************
    localparam logic [31:0] CRC_FAST_RST_MASK = 32'h0000_5a3d;
    localparam logic [31:0] CRC_SLOW_RST_MASK = 32'h9a6e_4807;
    localparam logic [31:0] CRC_RST_VALUE = 32'h0000_0000;
    localparam logic [4:0] CRC_IE_RESET = 5'h00;
    localparam int CRC_BIT_SUPV_EN = 0;

    // ready sources: bit 4 pll, 3 fast ext, 2 fast int, 1 slow ext, 0 slow int
    typedef struct packed {
        logic [4:0] ready;
        logic fail;
    } crc_events_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } crc_bus_req_t;

endpackage : crc_pkg

// ---- crc_sticky_flag.sv ----
`timescale 1ns/1ps
module crc_sticky_flag (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // event and clear
    input wire logic set_in,
    input wire logic clr_in,
    // flag
    output logic flag_out
);
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            // a set in the clearing cycle is kept  see RULE24
            flag_out <= 1'b1;
        end else if (clr_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule : crc_sticky_flag

// ---- crc_clock_events.sv ----
`timescale 1ns/1ps
// Functional notes
// RULE1: clock failure sets read-only flag bit 7
// RULE2: write 1 at bit 23 clears failure
// RULE3: pll lock sets sticky flag bit 4
// RULE4: write 1 at bit 20 clears pll
// RULE5: fast external ready flag 3, clear 19
// RULE6: fast internal ready flag 2, clear 18
// RULE7: slow external ready flag 1, clear 17
// RULE8: slow internal ready flag 0, clear 16
// RULE9: ready enables at bits 12 down to 8
// RULE10: fast bus bits 14, 12 reset serial
// RULE11: fast bus bit 11 resets advanced timer
// RULE12: fast bus bit 9 resets converter
// RULE13: fast bus bits 5..2 reset ports D..A
// RULE14: fast bus bit 0 resets alt function
// RULE15: slow bus bit 31 resets low-power timer
// RULE16: slow bus 28 power, 27 backup
// RULE17: slow bus bit 25 resets can controller
// RULE18: slow bus 22, 21 reset two-wire ports
// RULE19: slow bus 19..17 reset serial ports
// RULE20: slow bus bit 14 resets serial periph two
// RULE21: slow bus 2..0 timers, 11 watchdog
// RULE22: irq on enabled ready or failure flag
// RULE23: module held in reset while bit is one
// RULE24: set wins over same-cycle clear
// RULE25: supervised failure forces internal fast oscillator
module crc_clock_events
    import crc_pkg::*;
#(
    parameter int NUM_READY = 5
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // oscillator status, levels
    input wire logic pll_locked_in,
    input wire logic ext_fast_osc_ready_in,
    input wire logic int_fast_osc_ready_in,
    input wire logic ext_slow_osc_ready_in,
    input wire logic int_slow_osc_ready_in,
    input wire logic ext_fast_osc_fail_in,
    input wire logic ext_fast_is_sysclk_in,
    // outputs
    output logic clock_irq_out,
    output logic force_int_fast_osc_out,
    output logic [31:0] fast_bus_module_resets_out,
    output logic [31:0] slow_bus_module_resets_out
);
    // ****************************************
    // elaboration check
    // ****************************************
    if (NUM_READY != CRC_NUM_READY) begin : g_bad_ready
        $error("crc_clock_events: NUM_READY must be 5");
    end

    // ****************************************
    // request decode
    // ****************************************
    crc_bus_req_t req;
    crc_events_t level;
    crc_events_t level_q;
    crc_events_t rise;
    logic wr_events;
    logic wr_fast;
    logic wr_slow;
    logic wr_supv;
    logic [4:0] ready_flags;
    logic fail_flag;
    logic [4:0] ready_ie_q;
    logic supv_en_q;
    logic [31:0] fast_rst_q;
    logic [31:0] slow_rst_q;
    logic [31:0] rd_mux;

    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
    assign wr_events = req.wr && (req.addr == CRC_OFS_EVENTS);
    assign wr_fast = req.wr && (req.addr == CRC_OFS_FAST_RST);
    assign wr_slow = req.wr && (req.addr == CRC_OFS_SLOW_RST);
    assign wr_supv = req.wr && (req.addr == CRC_OFS_SUPV_CTRL);

    assign level.ready = {pll_locked_in, ext_fast_osc_ready_in, int_fast_osc_ready_in,
                          ext_slow_osc_ready_in, int_slow_osc_ready_in};
    assign level.fail = ext_fast_osc_fail_in;

    // ****************************************
    // event detection
    // ****************************************
    // flags set on the rising edge of each status, so a held level
    // does not re-raise a flag that software has just cleared
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            level_q <= '0;
        end else begin
            level_q <= level;
        end
    end

    assign rise = level & ~level_q;

    // ****************************************
    // sticky flags
    // ****************************************
    for (genvar i = 0; i < CRC_NUM_READY; i++) begin : g_ready
        crc_sticky_flag u_ready (
            .clk_in(clk_in),
            .arst_n_in(arst_n_in),
            .set_in(rise.ready[i]), // see RULE3 see RULE5 see RULE6 see RULE7 see RULE8
            .clr_in(wr_events && req.wdata[CRC_BIT_READY_CLR + i]), // see RULE4
            .flag_out(ready_flags[i])
        );
    end

    crc_sticky_flag u_fail (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .set_in(rise.fail), // see RULE1
        .clr_in(wr_events && req.wdata[CRC_BIT_FAIL_CLR]), // see RULE2
        .flag_out(fail_flag)
    );

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ready_ie_q <= CRC_IE_RESET;
        end else if (wr_events) begin
            ready_ie_q <= req.wdata[CRC_BIT_READY_IE +: CRC_NUM_READY]; // see RULE9
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            supv_en_q <= 1'b0;
        end else if (wr_supv) begin
            supv_en_q <= req.wdata[CRC_BIT_SUPV_EN];
        end
    end

    // ****************************************
    // module reset registers
    // ****************************************
    // a bit keeps its module in reset until software writes it back to 0
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fast_rst_q <= CRC_RST_VALUE;
        end else if (wr_fast) begin
            // see RULE10 see RULE11 see RULE12 see RULE13 see RULE14
            fast_rst_q <= req.wdata & CRC_FAST_RST_MASK;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            slow_rst_q <= CRC_RST_VALUE;
        end else if (wr_slow) begin
            // see RULE15 see RULE16 see RULE17 see RULE18 see RULE19 see RULE20 see RULE21
            slow_rst_q <= req.wdata & CRC_SLOW_RST_MASK;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fast_bus_module_resets_out <= CRC_RST_VALUE;
            slow_bus_module_resets_out <= CRC_RST_VALUE;
        end else begin
            fast_bus_module_resets_out <= fast_rst_q; // see RULE23
            slow_bus_module_resets_out <= slow_rst_q; // see RULE23
        end
    end

    // ****************************************
    // interrupt and supervision
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            clock_irq_out <= 1'b0;
        end else begin
            clock_irq_out <= (|(ready_flags & ready_ie_q)) || fail_flag; // see RULE22
        end
    end

    // the force holds until the failure flag is cleared by software and the failure input is low
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            force_int_fast_osc_out <= 1'b0;
        end else if (supv_en_q && ext_fast_is_sysclk_in && ext_fast_osc_fail_in) begin
            force_int_fast_osc_out <= 1'b1; // see RULE25
        end else if (!fail_flag && !ext_fast_osc_fail_in) begin
            force_int_fast_osc_out <= 1'b0;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // clear bits are write-only and read back as zero
    always_comb begin
        rd_mux = '0;
        case (req.addr)
            CRC_OFS_EVENTS: begin
                rd_mux[CRC_BIT_READY_FLAG +: CRC_NUM_READY] = ready_flags;
                rd_mux[CRC_BIT_FAIL_FLAG] = fail_flag;
                rd_mux[CRC_BIT_READY_IE +: CRC_NUM_READY] = ready_ie_q;
            end
            CRC_OFS_FAST_RST: begin
                rd_mux = fast_rst_q;
            end
            CRC_OFS_SLOW_RST: begin
                rd_mux = slow_rst_q;
            end
            CRC_OFS_SUPV_CTRL: begin
                rd_mux[CRC_BIT_SUPV_EN] = supv_en_q;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= '0;
        end else if (req.rd) begin
            reg_rdata_out <= rd_mux;
        end else begin
            reg_rdata_out <= '0;
        end
    end

endmodule : crc_clock_events

// ---- crc_clock_events_asserts.sv ----
`timescale 1ns/1ps
module crc_clock_events_asserts
    import crc_pkg::*;
#(
    parameter int NUM_READY = 5
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // oscillator status
    input wire logic ext_fast_osc_fail_in,
    input wire logic ext_fast_is_sysclk_in,
    // outputs
    input wire logic clock_irq_out,
    input wire logic force_int_fast_osc_out,
    input wire logic [31:0] fast_bus_module_resets_out,
    input wire logic [31:0] slow_bus_module_resets_out
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    a_fast_write: assert property (reg_wr_in && reg_addr_in == CRC_OFS_FAST_RST |-> ##2
        fast_bus_module_resets_out == ($past(reg_wdata_in, 2) & CRC_FAST_RST_MASK))
        else $error("fast reset output differs from write");
    a_slow_write: assert property (reg_wr_in && reg_addr_in == CRC_OFS_SLOW_RST |-> ##2
        slow_bus_module_resets_out == ($past(reg_wdata_in, 2) & CRC_SLOW_RST_MASK))
        else $error("slow reset output differs from write");
    // a module stays in reset until software writes it free
    a_fast_hold: assert property ($changed(fast_bus_module_resets_out) |->
        $past(reg_wr_in, 2) && $past(reg_addr_in, 2) == CRC_OFS_FAST_RST)
        else $error("fast reset output moved without write");
    a_slow_hold: assert property ($changed(slow_bus_module_resets_out) |->
        $past(reg_wr_in, 2) && $past(reg_addr_in, 2) == CRC_OFS_SLOW_RST)
        else $error("slow reset output moved without write");
    a_fail_irq: assert property ($rose(ext_fast_osc_fail_in) |-> ##[1:4] clock_irq_out)
        else $error("clock failure raised no irq");
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
        else $error("read data outside read slot");
    a_event_reserved: assert property ($past(reg_rd_in) &&
        $past(reg_addr_in) == CRC_OFS_EVENTS |-> (reg_rdata_out & 32'hffff_e060) == 32'h0000_0000)
        else $error("clear or reserved bits read nonzero");
    a_force_cause: assert property ($rose(force_int_fast_osc_out) |->
        $past(ext_fast_is_sysclk_in) && $past(ext_fast_osc_fail_in))
        else $error("force without failure of system clock");
endmodule : crc_clock_events_asserts
bind crc_clock_events crc_clock_events_asserts #(.NUM_READY(NUM_READY)) i_chk (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .ext_fast_osc_fail_in(ext_fast_osc_fail_in),
    .ext_fast_is_sysclk_in(ext_fast_is_sysclk_in), .clock_irq_out(clock_irq_out),
    .force_int_fast_osc_out(force_int_fast_osc_out),
    .fast_bus_module_resets_out(fast_bus_module_resets_out),
    .slow_bus_module_resets_out(slow_bus_module_resets_out));

// ---- test_crc_clock_events.sv ----
`timescale 1ns/1ps
module test_crc_clock_events;
    import crc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, sys = 1'b0, fail = 1'b0;
    logic irq, frc;
    logic [4:0] rdy = 5'h00;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdata, fst, slw, d, m;
    logic [31:0] exp_q[$];
    int n_fail = 0, checks = 0, cyc = 0, seed = 32'hb643_330e;
    crc_clock_events i_dut (.clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .pll_locked_in(rdy[4]), .ext_fast_osc_ready_in(rdy[3]), .int_fast_osc_ready_in(rdy[2]),
        .ext_slow_osc_ready_in(rdy[1]), .int_slow_osc_ready_in(rdy[0]),
        .ext_fast_osc_fail_in(fail), .ext_fast_is_sysclk_in(sys), .clock_irq_out(irq),
        .force_int_fast_osc_out(frc), .fast_bus_module_resets_out(fst),
        .slow_bus_module_resets_out(slw));
    initial forever #25 clk = ~clk;
    // ****************************************
    // bus tasks and scoreboard
    // ****************************************
    task end_sim;
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task w(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : w
    task r(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : r
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) if (rd_d) chk("read data", exp_q.pop_front(), rdata);
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        r(CRC_OFS_EVENTS, 32'h0000_0000);
        r(CRC_OFS_FAST_RST, 32'h0000_0000);
        r(8'h04, 32'h0000_0000);
        w(CRC_OFS_EVENTS, 32'hffff_ffff);
        r(CRC_OFS_EVENTS, 32'h0000_1f00);
        for (int k = 0; k < 10; k++) begin
            d = (k < 2) ? 32'hffff_ffff : ((k > 7) ? 32'h0000_0000 : $random(seed));
            m = k[0] ? CRC_SLOW_RST_MASK : CRC_FAST_RST_MASK;
            w(k[0] ? CRC_OFS_SLOW_RST : CRC_OFS_FAST_RST, d);
            r(k[0] ? CRC_OFS_SLOW_RST : CRC_OFS_FAST_RST, d & m);
            chk("module resets", d & m, k[0] ? slw : fst);
        end
        w(CRC_OFS_SLOW_RST, 32'hffff_ffff);
        r(CRC_OFS_SLOW_RST, 32'h9a6e_4807);
        w(CRC_OFS_SLOW_RST, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            m = 32'h0000_0100 << i;
            w(CRC_OFS_EVENTS, 32'h0000_0000);
            rdy[i] <= 1'b1;
            settle(4);
            chk("irq", 0, irq);
            w(CRC_OFS_EVENTS, m);
            settle(3);
            chk("irq", 1, irq);
            r(CRC_OFS_EVENTS, m | (1 << i));
            w(CRC_OFS_EVENTS, m);
            r(CRC_OFS_EVENTS, m | (1 << i));
            w(CRC_OFS_EVENTS, m | (32'h0001_0000 << i));
            r(CRC_OFS_EVENTS, m);
            settle(2);
            chk("irq", 0, irq);
            rdy[i] <= 1'b0;
        end
        // clear lands on the very edge that sets the flag
        w(CRC_OFS_EVENTS, 32'h0000_0000);
        @(posedge clk);
        addr <= CRC_OFS_EVENTS;
        wd <= 32'h0010_0000;
        wr <= 1'b1;
        rdy[4] <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        r(CRC_OFS_EVENTS, 32'h0000_0010);
        fail <= 1'b1;
        settle(4);
        chk("irq", 1, irq);
        chk("force", 0, frc);
        r(CRC_OFS_EVENTS, 32'h0000_0090);
        w(CRC_OFS_EVENTS, 32'h0090_0000);
        r(CRC_OFS_EVENTS, 32'h0000_0000);
        fail <= 1'b0;
        w(CRC_OFS_SUPV_CTRL, 32'h0000_0001);
        r(CRC_OFS_SUPV_CTRL, 32'h0000_0001);
        sys <= 1'b1;
        fail <= 1'b1;
        settle(4);
        chk("force", 1, frc);
        fail <= 1'b0;
        w(CRC_OFS_EVENTS, 32'h0080_0000);
        settle(3);
        chk("force", 0, frc);
        end_sim();
    end
endmodule : test_crc_clock_events
